/* File: rtl/lahp_pkg.sv */
package lahp_pkg;

	// Address decode: full I/O address, window base alignment and size.
	localparam int          ADDR_W       = 16;
	localparam int          DECODE_W     = 10;
	localparam int          BLOCK_W      = 4;

	// Port offsets inside the sixteen-location block.
	localparam logic [3:0]  OFS_FM_L_SEL = 4'h0;
	localparam logic [3:0]  OFS_FM_L_DAT = 4'h1;
	localparam logic [3:0]  OFS_FM_R_SEL = 4'h2;
	localparam logic [3:0]  OFS_FM_R_DAT = 4'h3;
	localparam logic [3:0]  OFS_MIX_IDX  = 4'h4;
	localparam logic [3:0]  OFS_MIX_DAT  = 4'h5;
	localparam logic [3:0]  OFS_IF_RST   = 4'h6;
	localparam logic [3:0]  OFS_FM_SEL   = 4'h8;
	localparam logic [3:0]  OFS_FM_DAT   = 4'h9;
	localparam logic [3:0]  OFS_RD_DATA  = 4'hA;
	localparam logic [3:0]  OFS_CMD      = 4'hC;
	localparam logic [3:0]  OFS_AVAIL    = 4'hE;

	// Mixer indices.
	localparam logic [7:0]  MIX_RESET    = 8'h00;
	localparam logic [7:0]  MIX_VOICE    = 8'h04;
	localparam logic [7:0]  MIX_MIC      = 8'h0A;
	localparam logic [7:0]  MIX_INPUT    = 8'h0C;
	localparam logic [7:0]  MIX_OUTPUT   = 8'h0E;
	localparam logic [7:0]  MIX_MASTER   = 8'h22;
	localparam logic [7:0]  MIX_FM       = 8'h26;
	localparam logic [7:0]  MIX_CD       = 8'h28;
	localparam logic [7:0]  MIX_LINE     = 8'h2E;

	// Mixer reset values.
	localparam logic [7:0]  RST_VOICE    = 8'h99;
	localparam logic [7:0]  RST_MIC      = 8'h01;
	localparam logic [7:0]  RST_INPUT    = 8'h00;
	localparam logic [7:0]  RST_OUTPUT   = 8'h00;
	localparam logic [7:0]  RST_MASTER   = 8'h99;
	localparam logic [7:0]  RST_FM       = 8'h99;
	localparam logic [7:0]  RST_CD       = 8'h01;
	localparam logic [7:0]  RST_LINE     = 8'h01;

	// Writable field masks; other bits read back as zero, except that MSK_STEREO is not applied.
	localparam logic [7:0]  MSK_MIC      = 8'h03;
	localparam logic [7:0]  MSK_INPUT    = 8'h06;
	localparam logic [7:0]  MSK_OUTPUT   = 8'h02;
	localparam logic [7:0]  MSK_STEREO   = 8'hEE;

	// Field positions.
	localparam int          BIT_IF_RST   = 0;
	localparam int          BIT_FLAG     = 7;
	localparam int          INSEL_LO     = 1;
	localparam int          STEREO_BIT   = 1;

	// Converter input source codes.
	localparam logic [1:0]  SRC_MIC      = 2'h0;
	localparam logic [1:0]  SRC_CD       = 2'h1;
	localparam logic [1:0]  SRC_LINE     = 2'h3;

	// Host I/O cycle.
	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
	} lahp_io_s;

	// Strobe toward an internal engine.
	typedef struct packed {
		logic       stb;
		logic [1:0] port;
		logic [7:0] data;
	} lahp_stb_s;

	// Mixer settings pushed to the main codec mixer.
	typedef struct packed {
		logic [7:0] voice;
		logic [7:0] mic;
		logic [1:0] in_src;
		logic       stereo;
		logic [7:0] master;
		logic [7:0] fm;
		logic [7:0] cd;
		logic [7:0] line;
	} lahp_mix_s;

	// Interface operating mode.
	typedef enum logic [1:0] {
		MODE_NATIVE = 2'b01,
		MODE_LEGACY = 2'b10
	} lahp_mode_e;

endpackage

/* File: rtl/lahp_port.sv */
`timescale 1ns/1ps
`default_nettype none

module lahp_port #(
	parameter int BASE_W = 10
) (
	input  wire logic               clock_i,
	input  wire logic               resetn_i,
	input  wire logic               ce_i,
	input  wire lahp_pkg::lahp_io_s io_i,
	input  wire logic [9:0]         legacy_port_base_i,
	input  wire logic [7:0]         fm_status_l_i,
	input  wire logic [7:0]         fm_status_r_i,
	input  wire logic               cmd_ready_i,
	input  wire logic               rd_valid_i,
	input  wire logic [7:0]         rd_data_i,
	input  wire logic               native_irq_i,
	input  wire logic               native_dma_req_i,
	input  wire logic               legacy_irq_i,
	input  wire logic               legacy_dma_req_i,
	input  wire logic               native_access_i,
	output logic [7:0]              rdata_o,
	output logic                    sel_o,
	output lahp_pkg::lahp_stb_s     fm_o,
	output lahp_pkg::lahp_stb_s     cmd_o,
	output logic                    rd_ack_o,
	output logic                    if_reset_o,
	output lahp_pkg::lahp_mix_s     mix_o,
	output logic                    mix_upd_o,
	output lahp_pkg::lahp_mode_e    mode_o,
	output logic                    irq_o,
	output logic                    dma_req_o
);

	// Width check: decoder serves exactly the ten-bit space.
	initial begin
		if (BASE_W != lahp_pkg::DECODE_W) begin
			$error("BASE_W must equal the decoded width");
		end
	end

	// Whole module state.
	typedef struct packed {
		logic [7:0]           rdata;
		logic                 sel;
		lahp_pkg::lahp_stb_s  fm;
		lahp_pkg::lahp_stb_s  cmd;
		logic                 rd_ack;
		logic                 rst_armed;
		logic                 if_reset;
		logic [7:0]           idx;
		lahp_pkg::lahp_mix_s  mix;
		logic                 mix_upd;
		lahp_pkg::lahp_mode_e mode;
		logic                 irq;
		logic                 dma;
	} lahp_state_s;

	lahp_state_s st_r;  // Registered state.
	lahp_state_s st_nxt; // Next state.

	logic        hit;     // Access lands in our block.
	logic [3:0]  ofs;     // Offset in the block.
	logic [7:0]  mix_rd;  // Indexed mixer readback.
	logic        mix_wr;  // Mixer data write strobe.
	lahp_pkg::lahp_mix_s mix_def; // Mixer default values.

	// Default mixer contents.
	always_comb begin
		mix_def.voice  = lahp_pkg::RST_VOICE;
		mix_def.mic    = lahp_pkg::RST_MIC;
		mix_def.in_src = lahp_pkg::RST_INPUT[2:1];
		mix_def.stereo = lahp_pkg::RST_OUTPUT[lahp_pkg::STEREO_BIT];
		mix_def.master = lahp_pkg::RST_MASTER;
		mix_def.fm     = lahp_pkg::RST_FM;
		mix_def.cd     = lahp_pkg::RST_CD;
		mix_def.line   = lahp_pkg::RST_LINE;
	end

	// Address decode: upper bits zero, base bits 9:4 match, 16 slots.
	always_comb begin
		hit = (io_i.addr[lahp_pkg::ADDR_W-1:lahp_pkg::DECODE_W] == '0)
			&& (io_i.addr[lahp_pkg::DECODE_W-1:lahp_pkg::BLOCK_W]
			== legacy_port_base_i[lahp_pkg::DECODE_W-1:lahp_pkg::BLOCK_W])
			&& (io_i.rd || io_i.wr);
		ofs = io_i.addr[lahp_pkg::BLOCK_W-1:0];
		mix_wr = hit && io_i.wr && (ofs == lahp_pkg::OFS_MIX_DAT);
	end

	// Readback of the indexed mixer register; unknown indices read zero.
	always_comb begin
		unique case (st_r.idx)
			lahp_pkg::MIX_VOICE:  mix_rd = st_r.mix.voice;
			lahp_pkg::MIX_MIC:    mix_rd = st_r.mix.mic;
			lahp_pkg::MIX_INPUT:  mix_rd = {5'h00, st_r.mix.in_src, 1'b0};
			lahp_pkg::MIX_OUTPUT: mix_rd = {6'h00, st_r.mix.stereo, 1'b0};
			lahp_pkg::MIX_MASTER: mix_rd = st_r.mix.master;
			lahp_pkg::MIX_FM:     mix_rd = st_r.mix.fm;
			lahp_pkg::MIX_CD:     mix_rd = st_r.mix.cd;
			lahp_pkg::MIX_LINE:   mix_rd = st_r.mix.line;
			default:              mix_rd = 8'h00;
		endcase
	end

	// Next-state logic for the whole port.
	always_comb begin
		st_nxt          = st_r;
		st_nxt.sel      = 1'b0;
		st_nxt.fm.stb   = 1'b0;
		st_nxt.cmd.stb  = 1'b0;
		st_nxt.rd_ack   = 1'b0;
		st_nxt.if_reset = 1'b0;
		st_nxt.mix_upd  = 1'b0;

		// Reads: answer one cycle after the request.
		if (hit && io_i.rd) begin
			st_nxt.sel   = 1'b1;
			st_nxt.rdata = 8'h00;
			unique case (ofs)
				lahp_pkg::OFS_FM_L_SEL,
				lahp_pkg::OFS_FM_SEL: begin
					st_nxt.rdata = fm_status_l_i;
				end
				lahp_pkg::OFS_FM_R_SEL: begin
					st_nxt.rdata = fm_status_r_i;
				end
				lahp_pkg::OFS_MIX_DAT: begin
					st_nxt.rdata = mix_rd;
				end
				lahp_pkg::OFS_RD_DATA: begin
					st_nxt.rdata  = rd_data_i;
					st_nxt.rd_ack = rd_valid_i;
				end
				lahp_pkg::OFS_CMD: begin
					st_nxt.rdata[lahp_pkg::BIT_FLAG] = cmd_ready_i;
				end
				lahp_pkg::OFS_AVAIL: begin
					st_nxt.rdata[lahp_pkg::BIT_FLAG] = rd_valid_i;
				end
				default: begin
					st_nxt.rdata = 8'h00;
				end
			endcase
		end

		// Writes.
		if (hit && io_i.wr) begin
			unique case (ofs)
				lahp_pkg::OFS_FM_L_SEL, lahp_pkg::OFS_FM_L_DAT,
				lahp_pkg::OFS_FM_R_SEL, lahp_pkg::OFS_FM_R_DAT: begin
					st_nxt.fm.stb  = 1'b1;
					st_nxt.fm.port = ofs[1:0];
					st_nxt.fm.data = io_i.wdata;
				end
				lahp_pkg::OFS_FM_SEL, lahp_pkg::OFS_FM_DAT: begin
					st_nxt.fm.stb  = 1'b1;
					st_nxt.fm.port = {1'b0, ofs[0]};
					st_nxt.fm.data = io_i.wdata;
				end
				lahp_pkg::OFS_MIX_IDX: begin
					st_nxt.idx = io_i.wdata;
				end
				lahp_pkg::OFS_IF_RST: begin
					// Arm on one, fire on the following zero.
					if (io_i.wdata[lahp_pkg::BIT_IF_RST]) begin
						st_nxt.rst_armed = 1'b1;
					end else if (st_r.rst_armed) begin
						st_nxt.rst_armed = 1'b0;
						st_nxt.if_reset  = 1'b1;
					end
				end
				lahp_pkg::OFS_CMD: begin
					st_nxt.cmd.stb  = 1'b1;
					st_nxt.cmd.port = 2'h0;
					st_nxt.cmd.data = io_i.wdata;
				end
				default: begin
					st_nxt.mix_upd = 1'b0;
				end
			endcase
		end

		// Indexed mixer writes; each one to a known index is mirrored out.
		if (mix_wr) begin
			st_nxt.mix_upd = 1'b1;
			unique case (st_r.idx)
				lahp_pkg::MIX_RESET:  st_nxt.mix = mix_def;
				lahp_pkg::MIX_VOICE:  st_nxt.mix.voice = io_i.wdata;
				lahp_pkg::MIX_MIC:    st_nxt.mix.mic =
					io_i.wdata & lahp_pkg::MSK_MIC;
				lahp_pkg::MIX_INPUT:  st_nxt.mix.in_src =
					io_i.wdata[lahp_pkg::INSEL_LO +: 2];
				lahp_pkg::MIX_OUTPUT: st_nxt.mix.stereo =
					io_i.wdata[lahp_pkg::STEREO_BIT];
				lahp_pkg::MIX_MASTER: st_nxt.mix.master = io_i.wdata;
				lahp_pkg::MIX_FM:     st_nxt.mix.fm = io_i.wdata;
				lahp_pkg::MIX_CD:     st_nxt.mix.cd = io_i.wdata;
				lahp_pkg::MIX_LINE:   st_nxt.mix.line = io_i.wdata;
				default:              st_nxt.mix_upd = 1'b0;
			endcase
		end

		// Interface reset puts the mixer back to defaults.
		if (st_r.if_reset) begin
			st_nxt.mix     = mix_def;
			st_nxt.idx     = lahp_pkg::MIX_RESET;
			st_nxt.mix_upd = 1'b1;
		end

		// Mode follows the last interface the host touched.
		if (hit) begin
			st_nxt.mode = lahp_pkg::MODE_LEGACY;
		end else if (native_access_i) begin
			st_nxt.mode = lahp_pkg::MODE_NATIVE;
		end

		// Shared interrupt and DMA request follow the active mode.
		st_nxt.irq = (st_nxt.mode == lahp_pkg::MODE_LEGACY)
			? legacy_irq_i : native_irq_i;
		st_nxt.dma = (st_nxt.mode == lahp_pkg::MODE_LEGACY)
			? legacy_dma_req_i : native_dma_req_i;
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r           <= '0;
			st_r.mix.voice <= lahp_pkg::RST_VOICE;
			st_r.mix.mic   <= lahp_pkg::RST_MIC;
			st_r.mix.master <= lahp_pkg::RST_MASTER;
			st_r.mix.fm    <= lahp_pkg::RST_FM;
			st_r.mix.cd    <= lahp_pkg::RST_CD;
			st_r.mix.line  <= lahp_pkg::RST_LINE;
			st_r.mode      <= lahp_pkg::MODE_NATIVE;
		end else if (ce_i) begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from state.
	assign rdata_o    = st_r.rdata;
	assign sel_o      = st_r.sel;
	assign fm_o       = st_r.fm;
	assign cmd_o      = st_r.cmd;
	assign rd_ack_o   = st_r.rd_ack;
	assign if_reset_o = st_r.if_reset;
	assign mix_o      = st_r.mix;
	assign mix_upd_o  = st_r.mix_upd;
	assign mode_o     = st_r.mode;
	assign irq_o      = st_r.irq;
	assign dma_req_o  = st_r.dma;

endmodule

`default_nettype wire

/* File: verif/lahp_port_properties.sv */
`timescale 1ns/1ps
`default_nettype none

// Pin-level checks of the legacy host port; all answers land one edge late.
module lahp_port_properties (
	input wire logic                clock_i,
	input wire logic                resetn_i,
	input wire logic                ce_i,
	input wire lahp_pkg::lahp_io_s  io_i,
	input wire logic [9:0]          legacy_port_base_i,
	input wire logic [7:0]          fm_status_l_i,
	input wire logic                cmd_ready_i,
	input wire logic                rd_valid_i,
	input wire logic [7:0]          rd_data_i,
	input wire logic [7:0]          rdata_o,
	input wire logic                sel_o,
	input wire lahp_pkg::lahp_stb_s fm_o,
	input wire lahp_pkg::lahp_stb_s cmd_o,
	input wire logic                rd_ack_o,
	input wire logic                if_reset_o,
	input wire lahp_pkg::lahp_mix_s mix_o,
	input wire logic                native_irq_i,
	input wire logic                legacy_irq_i,
	input wire logic                irq_o,
	input wire lahp_pkg::lahp_mode_e mode_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	logic       hit; // Cycle lands inside our block this edge.
	logic [3:0] of;  // Offset inside the block.
	assign hit = ce_i && io_i.addr[15:4] == {6'h00, legacy_port_base_i[9:4]};
	assign of = io_i.addr[3:0];
	property p_sel; hit && io_i.rd |=> sel_o; endproperty
	a_sel: assert property (p_sel) else $error("read missed");
	property p_quiet; !(hit && io_i.rd) |=> !sel_o; endproperty
	a_quiet: assert property (p_quiet) else $error("stray answer");
	property p_fmw;
		hit && io_i.wr && of == 4'h9 |=> fm_o.stb && fm_o.port == 2'h1
			&& fm_o.data == $past(io_i.wdata);
	endproperty
	a_fmw: assert property (p_fmw) else $error("fm data lost");
	property p_fmr;
		hit && io_i.rd && of == 4'h0 |=> rdata_o == $past(fm_status_l_i);
	endproperty
	a_fmr: assert property (p_fmr) else $error("fm status");
	property p_cmd;
		hit && io_i.wr && of == 4'hC |=> cmd_o.stb && cmd_o.data == $past(io_i.wdata);
	endproperty
	a_cmd: assert property (p_cmd) else $error("command lost");
	property p_rdy;
		hit && io_i.rd && of == 4'hC |=> rdata_o[7] == $past(cmd_ready_i);
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready flag");
	property p_ack;
		hit && io_i.rd && of == 4'hA && rd_valid_i |=> rd_ack_o
			&& rdata_o == $past(rd_data_i);
	endproperty
	a_ack: assert property (p_ack) else $error("read data");
	property p_rst;
		if_reset_o |=> mix_o.master == 8'h99 && mix_o.cd == 8'h01 ##1 !if_reset_o;
	endproperty
	a_rst: assert property (p_rst) else $error("mixer not reset");
	// Any decoded access must leave the port in the legacy mode.
	property p_mode;
		hit && (io_i.rd || io_i.wr) |=> mode_o == lahp_pkg::MODE_LEGACY;
	endproperty
	a_mode: assert property (p_mode) else $error("mode not legacy");
	// The shared interrupt line follows whichever mode is now active.
	property p_irq;
		ce_i |=> irq_o == ((mode_o == lahp_pkg::MODE_LEGACY)
			? $past(legacy_irq_i) : $past(native_irq_i));
	endproperty
	a_irq: assert property (p_irq) else $error("irq not muxed");
endmodule

bind lahp_port lahp_port_properties i_lahp_port_properties (.clock_i, .resetn_i,
	.ce_i, .io_i, .legacy_port_base_i, .fm_status_l_i, .cmd_ready_i,
	.rd_valid_i, .rd_data_i, .rdata_o, .sel_o, .fm_o, .cmd_o, .rd_ack_o,
	.if_reset_o, .mix_o, .native_irq_i, .legacy_irq_i, .irq_o, .mode_o);

`default_nettype wire

/* File: verif/lahp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Host bus master: one-cycle I/O strobes launched off the falling edge.
module lahp_host_model (
	input  wire logic              clock_i,
	output var lahp_pkg::lahp_io_s io_o
);
	initial io_o = '0;
	// Released lines show inverted junk so a stale value never looks valid.
	task automatic cyc(input logic r, input logic [15:0] a, input logic [7:0] d);
		@(negedge clock_i);
		io_o = '{rd: r, wr: !r, addr: a, wdata: d};
		@(negedge clock_i);
		io_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask
	// Index always goes out before the data access.
	task automatic mix(input logic [15:0] b, input logic [7:0] i, input logic r,
		input logic [7:0] d);
		cyc(1'b0, b | 16'h0004, i);
		cyc(r, b | 16'h0005, d);
	endtask
	// Interface reset is bit 0 raised and then dropped.
	task automatic if_reset(input logic [15:0] b);
		cyc(1'b0, b | 16'h0006, 8'h01);
		cyc(1'b0, b | 16'h0006, 8'h00);
	endtask
endmodule

`default_nettype wire

/* File: verif/lahp_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench: reads note {mask, value}; a monitor pops on answers.
module lahp_port_tb;
	logic               clock_i  = 1'b0;
	logic               resetn_i = 1'b0;
	logic               ce_i     = 1'b1;
	logic               nacc     = 1'b0;
	logic               lirq     = 1'b1; // Legacy interrupt, held active.
	logic               rdy      = 1'b0;
	logic               vld      = 1'b0;
	logic [7:0]         fsl      = 8'h00;
	logic [7:0]         fsr      = 8'h00;
	logic [7:0]         rdat     = 8'h00;
	logic [7:0]         v;
	logic [9:0]         base     = 10'h220;
	logic [7:0]         rdata;
	logic               sel;
	lahp_pkg::lahp_io_s io;
	logic [15:0]        q[$];
	int                 errors          = 0;
	int                 samples_checked = 0;
	int                 seed            = 32'he81f9248;
	logic [7:0] idx[8] = '{8'h04, 8'h0A, 8'h0C, 8'h0E, 8'h22, 8'h26, 8'h28, 8'h2E};
	logic [7:0] dfl[8] = '{8'h99, 8'h01, 8'h00, 8'h00, 8'h99, 8'h99, 8'h01, 8'h01};
	logic [7:0] msk[8] = '{8'hFF, 8'h03, 8'h06, 8'h02, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	wire logic [15:0]   blk      = {6'h00, base[9:4], 4'h0};

	always #2 clock_i = ~clock_i;
	lahp_host_model i_lahp_host_model (.clock_i(clock_i), .io_o(io));
	lahp_port i_lahp_port (.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i),
		.io_i(io), .legacy_port_base_i(base), .fm_status_l_i(fsl),
		.fm_status_r_i(fsr), .cmd_ready_i(rdy), .rd_valid_i(vld),
		.rd_data_i(rdat), .native_irq_i(1'b0), .native_dma_req_i(1'b0),
		.legacy_irq_i(lirq), .legacy_dma_req_i(1'b0), .native_access_i(nacc),
		.rdata_o(rdata), .sel_o(sel), .fm_o(), .cmd_o(), .rd_ack_o(),
		.if_reset_o(), .mix_o(), .mix_upd_o(), .mode_o(), .irq_o(),
		.dma_req_o());

	task automatic fail(input string m);
		errors++;
		$display("CHECK FAILED at %0t: %s", $time, m);
	endtask
	task automatic give_verdict;
		$display("compared %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk_rd(input logic [15:0] n);
		samples_checked++;
		if ((rdata & n[15:8]) !== n[7:0])
			fail("read data mismatch");
	endtask
	task automatic wr(input logic [3:0] o, input logic [7:0] d);
		i_lahp_host_model.cyc(1'b0, blk | 16'(o), d);
	endtask
	task automatic rd(input logic [3:0] o, input logic [7:0] e, m);
		q.push_back({m, e});
		i_lahp_host_model.cyc(1'b1, blk | 16'(o), 8'h00);
	endtask
	task automatic mwr(input logic [7:0] i, d);
		i_lahp_host_model.mix(blk, i, 1'b0, d);
	endtask
	task automatic mrd(input logic [7:0] i, e);
		q.push_back({8'hFF, e});
		i_lahp_host_model.mix(blk, i, 1'b1, 8'h00);
	endtask
	task automatic defaults;
		for (int i = 0; i < 8; i++)
			mrd(idx[i], dfl[i]);
	endtask

	// Answers are settled registers by the falling edge.
	always @(negedge clock_i) begin
		if (sel === 1'b1) begin
			if (q.size() == 0)
				fail("unexpected answer");
			else
				chk_rd(q.pop_front());
		end
	end

	// Watchdog cuts a hang short.
	initial begin
		repeat (20000) @(posedge clock_i);
		fail("timeout");
		give_verdict();
	end

	initial begin
		repeat (4) @(posedge clock_i);
		@(negedge clock_i) resetn_i = 1'b1;
		defaults();
		for (int i = 0; i < 8; i++) begin
			v = 8'($random(seed));
			mwr(idx[i], v);
			mrd(idx[i], v & msk[i]);
		end
		for (int k = 0; k < 4; k++) begin
			mwr(8'h0C, 8'(k << 1));
			mrd(8'h0C, 8'(k << 1));
		end
		mwr(8'h02, 8'hFF);
		mrd(8'h02, 8'h00);
		mwr(8'h00, 8'h5A);
		defaults();
		mwr(8'h22, 8'h12);
		i_lahp_host_model.if_reset(blk);
		defaults();
		$display("mixer tests done");
		fsl = 8'($random(seed));
		fsr = 8'($random(seed));
		rdat = 8'($random(seed));
		rd(4'h0, fsl, 8'hFF);
		rd(4'h2, fsr, 8'hFF);
		rd(4'h8, fsl, 8'hFF);
		wr(4'h9, fsr);
		for (int k = 0; k < 2; k++) begin
			rdy = k[0];
			vld = k[0];
			rd(4'hC, {rdy, 7'h00}, 8'h80);
			rd(4'hE, {vld, 7'h00}, 8'h80);
		end
		rd(4'hA, rdat, 8'hFF);
		wr(4'hC, rdat);
		rd(4'hF, 8'h00, 8'hFF);
		i_lahp_host_model.cyc(1'b1, blk | 16'h0400, 8'h00);
		i_lahp_host_model.cyc(1'b1, blk ^ 16'h0010, 8'h00);
		ce_i = 1'b0;
		i_lahp_host_model.cyc(1'b1, blk, 8'h00);
		ce_i = 1'b1;
		nacc = 1'b1;
		@(negedge clock_i) nacc = 1'b0;
		rd(4'h0, fsl, 8'hFF);
		$display("port tests done");
		repeat (4) @(negedge clock_i);
		samples_checked++;
		if (q.size() != 0)
			fail("answers missing");
		give_verdict();
	end
endmodule

`default_nettype wire
